// ===== logic/mrsg_seq_group.sv
// Purpose: rail ordering, tracking setup and group membership
// Assumes: byte-addressed 32-bit command write/read port, events already decoded
// Notes: analog tracking loop lies outside; only its controls leave here
`timescale 1ns/100ps
`include "mrsg_regs.svh"

// Function
// - prequel: on needs enable and prequel good
// - sequel: off after sequel power-down, delayed
// - ordering register: ids at 12:8, 4:0
// - bits 15 and 7 enable prequel, sequel
// - written ordering overrides strap configuration
// - ordering resets zero, unused bits zero
// - tracking byte, bit 7 enables, resets zero
// - ratio bit: 0 full, 1 half
// - limit bit: 0 target, 1 reference
// - no tracking in 4/6/8-phase groups
// - voltage command broadcast matched at 20:16
// - operation broadcast matched at 12:8
// - supply-loss: immediate or sequenced shutdown
// - own broadcasts carry configured group id
// - two-phase spreads supply-loss regardless of group
// - group resets from strap, unused zero
module mrsg_seq_group
    import mrsg_pkg::*;
#(
    parameter int DLY_W = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Straps; order and group sampled after reset release, phase mode read directly, phase index unused
    input wire logic [15:0] strap_order_i,
    input wire logic strap_order_use_i,
    input wire logic [31:0] strap_group_i,
    input wire logic [1:0] phase_mode_i,
    input wire logic phase_idx_i,
    // Command register port
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    output logic [31:0] rdata_o,
    output logic ack_o,
    // Enable state and delays
    input wire logic on_req_i,
    input wire logic [DLY_W-1:0] off_dly_i,
    // Inbound events
    input wire logic good_evt_i,
    input wire logic pd_evt_i,
    input wire logic oper_evt_i,
    input wire logic vcmd_evt_i,
    input wire logic fail_evt_i,
    input wire logic [4:0] evt_id_i,
    // Own events to send
    input wire logic send_fail_i,
    input wire logic send_oper_i,
    input wire logic send_vcmd_i,
    output logic tx_evt_o,
    output logic [4:0] tx_id_o,
    // Actions
    output logic output_on_o,
    output logic oper_apply_o,
    output logic vcmd_apply_o,
    output logic fail_off_o,
    // Tracking controls and sequencer state
    output logic follow_en_o,
    output logic follow_half_o,
    output logic follow_ref_limit_o,
    output logic [2:0] state_o
);
    // ************************************************************
    // Parameter check
    // ************************************************************
    // Delay port and counter share DLY_W; zero width cannot count
    if (DLY_W < 1 || DLY_W > 32) begin
        $error("DLY_W out of range");
    end

    // ************************************************************
    // Reset release and strap capture
    // ************************************************************
    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic strap_done_reg;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            strap_done_reg <= 1'b0;
        end else begin
            strap_done_reg <= 1'b1;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    logic [15:0] order_reg;
    logic order_written_reg;
    logic [7:0] follow_reg;
    logic [31:0] group_reg;
    logic wr_order, wr_follow, wr_group;
    logic multi_phase;

    assign wr_order = wr_i && (addr_i == `MRSG_OFS_ORDER);
    assign wr_follow = wr_i && (addr_i == `MRSG_OFS_FOLLOW);
    assign wr_group = wr_i && (addr_i == `MRSG_OFS_GROUP);
    assign multi_phase = (phase_mode_i == MRSG_PH_MULTI);

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            order_reg <= `MRSG_ORDER_RST;
            order_written_reg <= 1'b0;
        end else if (wr_order) begin
            order_reg <= wdata_i[15:0] & `MRSG_ORDER_MASK;
            order_written_reg <= 1'b1;
        end else if (!strap_done_reg && strap_order_use_i && !order_written_reg) begin
            // Strap fills in once, on the first edge out of internal reset, unless software has spoken
            order_reg <= strap_order_i & `MRSG_ORDER_MASK;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            follow_reg <= `MRSG_FOLLOW_RST;
        end else if (wr_follow) begin
            follow_reg <= wdata_i[7:0] & `MRSG_FOLLOW_MASK;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            group_reg <= 32'h00000000;
        end else if (wr_group) begin
            group_reg <= wdata_i & `MRSG_GROUP_MASK;
        end else if (!strap_done_reg) begin
            group_reg <= strap_group_i & `MRSG_GROUP_MASK;
        end
    end

    always_comb begin
        rdata_o = 32'h00000000;
        unique case (addr_i)
            `MRSG_OFS_ORDER: rdata_o = {16'h0000, order_reg};
            `MRSG_OFS_FOLLOW: rdata_o = {24'h000000, follow_reg};
            `MRSG_OFS_GROUP: rdata_o = group_reg;
            default: rdata_o = 32'h00000000;
        endcase
    end
    // Unmapped codes get no ack, so the host sees them refused
    assign ack_o = (rd_i || wr_i) &&
        (addr_i == `MRSG_OFS_ORDER || addr_i == `MRSG_OFS_FOLLOW ||
         addr_i == `MRSG_OFS_GROUP);

    // ************************************************************
    // Tracking controls
    // ************************************************************
    // Tracking refused in wide current-sharing groups
    assign follow_en_o = follow_reg[`MRSG_FOLLOW_EN] && !multi_phase;
    assign follow_half_o = follow_reg[`MRSG_FOLLOW_RATIO];
    assign follow_ref_limit_o = follow_reg[`MRSG_FOLLOW_LIMIT];

    // ************************************************************
    // Event matching
    // ************************************************************
    logic pre_hit, seq_hit, oper_hit, vcmd_hit, fail_hit;
    logic fail_match;

    mrsg_event_match u_pre (
        .evt_i(good_evt_i),
        .evt_id_i(evt_id_i),
        .en_i(order_reg[`MRSG_ORDER_PRE_EN]),
        .own_id_i(order_reg[12:8]),
        .hit_o(pre_hit)
    );
    mrsg_event_match u_seq (
        .evt_i(pd_evt_i),
        .evt_id_i(evt_id_i),
        .en_i(order_reg[`MRSG_ORDER_SEQ_EN]),
        .own_id_i(order_reg[4:0]),
        .hit_o(seq_hit)
    );
    mrsg_event_match u_oper (
        .evt_i(oper_evt_i),
        .evt_id_i(evt_id_i),
        .en_i(group_reg[`MRSG_GROUP_OPER_EN]),
        .own_id_i(group_reg[12:8]),
        .hit_o(oper_hit)
    );
    mrsg_event_match u_vcmd (
        .evt_i(vcmd_evt_i),
        .evt_id_i(evt_id_i),
        .en_i(group_reg[`MRSG_GROUP_VCMD_EN]),
        .own_id_i(group_reg[20:16]),
        .hit_o(vcmd_hit)
    );
    mrsg_event_match u_fail (
        .evt_i(fail_evt_i),
        .evt_id_i(evt_id_i),
        .en_i(1'b1),
        .own_id_i(group_reg[4:0]),
        .hit_o(fail_match)
    );
    // Two-phase pair answers supply-loss as one, ignoring group setup
    assign fail_hit = fail_match || (fail_evt_i && phase_mode_i == MRSG_PH_TWO);

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            oper_apply_o <= 1'b0;
            vcmd_apply_o <= 1'b0;
        end else begin
            oper_apply_o <= oper_hit;
            vcmd_apply_o <= vcmd_hit;
        end
    end

    // ************************************************************
    // Outbound events
    // ************************************************************
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tx_evt_o <= 1'b0;
            tx_id_o <= 5'h00;
        end else begin
            tx_evt_o <= send_fail_i || send_oper_i || send_vcmd_i;
            // Supply-loss first: it is the most urgent
            if (send_fail_i) begin
                tx_id_o <= group_reg[4:0];
            end else if (send_oper_i) begin
                tx_id_o <= group_reg[12:8];
            end else if (send_vcmd_i) begin
                tx_id_o <= group_reg[20:16];
            end
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    mrsg_state_t state_reg, state_next;
    logic [DLY_W-1:0] dly_reg;
    logic fail_imm;
    assign fail_imm = fail_hit && group_reg[`MRSG_GROUP_FAIL_IMM];

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            MRSG_OFF: begin
                if (on_req_i) begin
                    state_next = MRSG_WAIT_PRE;
                end
            end
            MRSG_WAIT_PRE: begin
                if (!on_req_i || fail_hit) begin
                    state_next = MRSG_OFF;
                end else if (!order_reg[`MRSG_ORDER_PRE_EN] || pre_hit) begin
                    state_next = MRSG_ON;
                end
            end
            MRSG_ON: begin
                if (fail_imm) begin
                    state_next = MRSG_OFF;
                end else if (fail_hit) begin
                    state_next = MRSG_STOP_DLY;
                end else if (!on_req_i) begin
                    state_next = order_reg[`MRSG_ORDER_SEQ_EN] ? MRSG_WAIT_SEQ : MRSG_STOP_DLY;
                end
            end
            MRSG_WAIT_SEQ: begin
                if (fail_imm) begin
                    state_next = MRSG_OFF;
                end else if (seq_hit || fail_hit) begin
                    state_next = MRSG_STOP_DLY;
                end
            end
            MRSG_STOP_DLY: begin
                if (fail_imm || dly_reg == '0) begin
                    state_next = MRSG_OFF;
                end
            end
            default: state_next = MRSG_OFF;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= MRSG_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // Loaded on entry to the stop delay; zero ends it
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            dly_reg <= '0;
        end else if (state_reg != MRSG_STOP_DLY && state_next == MRSG_STOP_DLY) begin
            dly_reg <= off_dly_i;
        end else if (state_reg == MRSG_STOP_DLY && dly_reg != '0) begin
            dly_reg <= dly_reg - 1'b1;
        end
    end

    // Taken from the next state so the output moves with the state
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            output_on_o <= 1'b0;
            fail_off_o <= 1'b0;
        end else begin
            output_on_o <= (state_next != MRSG_OFF) && (state_next != MRSG_WAIT_PRE);
            fail_off_o <= fail_hit;
        end
    end

    // ************************************************************
    // Status
    // ************************************************************
    always_comb begin
        unique case (state_reg)
            MRSG_OFF: state_o = 3'h0;
            MRSG_WAIT_PRE: state_o = 3'h1;
            MRSG_ON: state_o = 3'h2;
            MRSG_WAIT_SEQ: state_o = 3'h3;
            MRSG_STOP_DLY: state_o = 3'h4;
            default: state_o = 3'h7;
        endcase
    end

    logic unused_idx;
    assign unused_idx = phase_idx_i;
endmodule

// ===== logic/mrsg_regs.svh
// Purpose: register offsets, field positions and reset values
// Assumes: included by bare name
// Notes: definitions only
`ifndef MRSG_REGS_SVH
`define MRSG_REGS_SVH

`define MRSG_OFS_ORDER 8'hE0
`define MRSG_OFS_FOLLOW 8'hE1
`define MRSG_OFS_GROUP 8'hE2

`define MRSG_ORDER_RST 16'h0000
`define MRSG_ORDER_MASK 16'h9F9F
`define MRSG_ORDER_PRE_EN 15
`define MRSG_ORDER_SEQ_EN 7

`define MRSG_FOLLOW_RST 8'h00
`define MRSG_FOLLOW_MASK 8'h86
`define MRSG_FOLLOW_EN 7
`define MRSG_FOLLOW_RATIO 2
`define MRSG_FOLLOW_LIMIT 1

`define MRSG_GROUP_MASK 32'h003F3F3F
`define MRSG_GROUP_VCMD_EN 21
`define MRSG_GROUP_OPER_EN 13
`define MRSG_GROUP_FAIL_IMM 5

`endif

// ===== logic/mrsg_pkg.sv
// Purpose: shared types of the rail sequencing block
// Assumes: nothing
// Notes: constants live in mrsg_regs.svh
package mrsg_pkg;
    typedef enum logic [4:0] {
        MRSG_OFF = 5'h01,
        MRSG_WAIT_PRE = 5'h02,
        MRSG_ON = 5'h04,
        MRSG_WAIT_SEQ = 5'h08,
        MRSG_STOP_DLY = 5'h10
    } mrsg_state_t;
    typedef enum logic [1:0] {
        MRSG_PH_SINGLE = 2'h0,
        MRSG_PH_TWO = 2'h1,
        MRSG_PH_MULTI = 2'h2
    } mrsg_phase_t;
endpackage

// ===== logic/mrsg_event_match.sv
// Purpose: match a decoded bus event against a 5-bit identifier
// Assumes: event strobe and id valid in the same cycle
// Notes: gated by an enable bit
`timescale 1ns/100ps
module mrsg_event_match (
    // Event
    input wire logic evt_i,
    input wire logic [4:0] evt_id_i,
    // Setup
    input wire logic en_i,
    input wire logic [4:0] own_id_i,
    // Result
    output logic hit_o
);
    assign hit_o = evt_i && en_i && (evt_id_i == own_id_i);
endmodule

// ===== bench/mrsg_seq_group_asserts.sv
// Purpose: port-level checks of the rail sequencing block
// Assumes: straps stay constant while the block is in use
// Notes: shadows the tracking and group registers from the write port
`timescale 1ns/100ps
module mrsg_seq_group_asserts (
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Inputs
    input wire logic [31:0] strap_group_i,
    input wire logic [1:0] phase_mode_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic oper_evt_i,
    input wire logic vcmd_evt_i,
    input wire logic [4:0] evt_id_i,
    input wire logic send_oper_i,
    input wire logic send_fail_i,
    // Outputs
    input wire logic [31:0] rdata_o,
    input wire logic ack_o,
    input wire logic tx_evt_o,
    input wire logic [4:0] tx_id_o,
    input wire logic oper_apply_o,
    input wire logic vcmd_apply_o,
    input wire logic follow_en_o,
    input wire logic follow_half_o,
    input wire logic follow_ref_limit_o
);
    // ****
    // Shadow registers
    // ****
    logic [7:0] trk_reg;
    logic [31:0] grp_reg;
    logic map_w;
    logic oper_hit;
    logic vcmd_hit;
    logic [4:0] oper_id;
    logic [2:0] rel_reg;
    assign map_w = addr_i inside {8'hE0, 8'hE1, 8'hE2};
    assign oper_id = grp_reg[12:8];
    assign oper_hit = oper_evt_i && grp_reg[13] && evt_id_i == oper_id;
    assign vcmd_hit = vcmd_evt_i && grp_reg[21] && evt_id_i == grp_reg[20:16];
    // Mirrors the two-stage reset release inside the block
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rel_reg <= 3'h0;
        end else begin
            rel_reg <= {rel_reg[1:0], 1'b1};
        end
    end
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            trk_reg <= 8'h00;
            grp_reg <= 32'h00000000;
        end else if (wr_i && addr_i == 8'hE1) begin
            trk_reg <= wdata_i[7:0];
        end else if (wr_i && addr_i == 8'hE2) begin
            grp_reg <= wdata_i & 32'h003F3F3F;
        end else if (rel_reg[1] && !rel_reg[2]) begin
            // Strap lands on the first edge out of internal reset
            grp_reg <= strap_group_i & 32'h003F3F3F;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    bus_ack_a: assert property (ack_o == ((wr_i || rd_i) && map_w))
        else $error("ack does not follow address decode");
    unmapped_zero_a: assert property (rd_i && !map_w |-> rdata_o == 32'h0)
        else $error("unmapped read not zero");
    half_ratio_a: assert property (follow_half_o == trk_reg[2])
        else $error("ratio output wrong");
    ref_limit_a: assert property (follow_ref_limit_o == trk_reg[1])
        else $error("limit output wrong");
    multi_track_a: assert property (phase_mode_i == 2'h2 |-> !follow_en_o)
        else $error("tracking on in multi-phase group");
    oper_match_a: assert property (oper_apply_o == $past(oper_hit))
        else $error("operation broadcast response wrong");
    vcmd_match_a: assert property (vcmd_apply_o == $past(vcmd_hit))
        else $error("voltage broadcast response wrong");
    tx_group_a: assert property (send_oper_i && !send_fail_i |=>
            tx_evt_o && tx_id_o == $past(oper_id))
        else $error("sent operation id wrong");
endmodule

bind mrsg_seq_group mrsg_seq_group_asserts chk (.clk_i, .nrst_i, .strap_group_i,
    .phase_mode_i, .wr_i, .rd_i, .addr_i, .wdata_i, .oper_evt_i, .vcmd_evt_i, .evt_id_i,
    .send_oper_i, .send_fail_i, .rdata_o, .ack_o, .tx_evt_o, .tx_id_o,
    .oper_apply_o, .vcmd_apply_o,
    .follow_en_o, .follow_half_o, .follow_ref_limit_o);

// ===== bench/mrsg_peer_model.sv
// Purpose: peer modules sending decoded events on the shared bus
// Assumes: caller enters just after a rising edge
// Notes: id line scrambled between events, never left at the last value
`timescale 1ns/100ps
module mrsg_peer_model (
    // Clock
    input wire logic clk_i,
    // Events: good, down, operation, voltage, supply loss
    output logic [4:0] evt_o,
    output logic [4:0] evt_id_o
);
    initial begin
        evt_o = 5'h00;
        evt_id_o = 5'h00;
    end
    // One-cycle strobe carrying its id
    task automatic emit(input int k, input logic [4:0] id);
        evt_o = 5'h01 << k;
        evt_id_o = id;
        @(posedge clk_i);
        #1;
        evt_o = 5'h00;
        evt_id_o = ~id;
    endtask
endmodule

// ===== bench/mrsg_seq_group_tb.sv
// Purpose: self-checking bench of the rail sequencing block
// Assumes: peer model drives the inbound events
// Notes: inputs move 1 ns after each rising edge
`timescale 1ns/100ps
module mrsg_seq_group_tb;
    logic clk_i = 1'h0, nrst_i = 1'h0, strap_order_use_i = 1'h0, phase_idx_i = 1'h0;
    logic wr_i = 1'h0, rd_i = 1'h0, on_req_i = 1'h0;
    logic send_fail_i = 1'h0, send_oper_i = 1'h0, send_vcmd_i = 1'h0;
    logic [15:0] strap_order_i = 16'h8A85, off_dly_i = 16'h0008;
    logic [31:0] strap_group_i = 32'hA5E72A95, wdata_i = 32'h0, rdata_o;
    logic [1:0] phase_mode_i = 2'h0;
    logic [7:0] addr_i = 8'h00;
    logic ack_o, tx_evt_o, output_on_o, oper_apply_o, vcmd_apply_o, fail_off_o;
    logic follow_en_o, follow_half_o, follow_ref_limit_o;
    logic [4:0] evt_o, evt_id_i, tx_id_o;
    logic [2:0] state_o;
    int err_count = 0, cmp_count = 0;
    mrsg_seq_group dut (.clk_i, .nrst_i, .strap_order_i, .strap_order_use_i, .strap_group_i,
        .phase_mode_i, .phase_idx_i, .wr_i, .rd_i, .addr_i, .wdata_i, .rdata_o, .ack_o,
        .on_req_i, .off_dly_i, .good_evt_i(evt_o[0]), .pd_evt_i(evt_o[1]),
        .oper_evt_i(evt_o[2]), .vcmd_evt_i(evt_o[3]), .fail_evt_i(evt_o[4]), .evt_id_i,
        .send_fail_i, .send_oper_i, .send_vcmd_i, .tx_evt_o, .tx_id_o, .output_on_o,
        .oper_apply_o, .vcmd_apply_o, .fail_off_o, .follow_en_o, .follow_half_o,
        .follow_ref_limit_o, .state_o);
    mrsg_peer_model peer (.clk_i, .evt_o, .evt_id_o(evt_id_i));
    always #50 clk_i = ~clk_i;
    // ****
    // Shared tasks
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] e);
        wr_i = w;
        rd_i = !w;
        addr_i = a;
        wdata_i = d;
        #1;
        chk({31'h0, ack_o}, {31'h0, a inside {8'hE0, 8'hE1, 8'hE2}});
        if (!w) chk(rdata_o, e);
        tick(1);
        wr_i = 1'h0;
        rd_i = 1'h0;
        // Idle edge keeps back-to-back calls from re-driving in one step
        tick(1);
    endtask
    task automatic on_is(input logic v);
        chk({31'h0, output_on_o}, {31'h0, v});
    endtask
    // Bounded wait; running out counts as a mismatch
    task automatic wait_on(input logic v);
        for (int n = 0; n < 40 && output_on_o !== v; n++) tick(1);
        on_is(v);
        if (output_on_o !== v) wrap_up();
    endtask
    task automatic bc(input int k, input logic [4:0] id, input logic [1:0] e);
        peer.emit(k, id);
        chk({30'h0, vcmd_apply_o, oper_apply_o}, {30'h0, e});
        tick(1);
    endtask
    task automatic tx(input int k, input logic [4:0] e);
        {send_vcmd_i, send_oper_i, send_fail_i} = 3'h1 << k;
        tick(1);
        {send_vcmd_i, send_oper_i, send_fail_i} = 3'h0;
        chk({26'h0, tx_evt_o, tx_id_o}, {26'h0, 1'h1, e});
        tick(1);
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_regs();
        acc(1'h0, 8'hE0, 32'h0, 32'h0);
        acc(1'h0, 8'hE1, 32'h0, 32'h0);
        acc(1'h0, 8'hE2, 32'h0, strap_group_i & 32'h003F3F3F);
        acc(1'h1, 8'hE0, 32'hFFFFFFFF, 32'h0);
        acc(1'h0, 8'hE0, 32'h0, 32'h9F9F);
        acc(1'h1, 8'hE1, 32'hFF, 32'h0);
        acc(1'h0, 8'hE1, 32'h0, 32'h86);
        acc(1'h1, 8'hE3, 32'hFF, 32'h0);
        acc(1'h0, 8'hE3, 32'h0, 32'h0);
        acc(1'h1, 8'hE2, 32'hFFFFFFFF, 32'h0);
        acc(1'h0, 8'hE2, 32'h0, 32'h003F3F3F);
        $display("regs done");
    endtask
    task automatic t_track();
        // Bench plays host; voltage target lies outside this block
        acc(1'h1, 8'hE1, 32'h86, 32'h0);
        chk({29'h0, follow_en_o, follow_half_o, follow_ref_limit_o}, 32'h7);
        acc(1'h1, 8'hE1, 32'h80, 32'h0);
        chk({29'h0, follow_en_o, follow_half_o, follow_ref_limit_o}, 32'h4);
        phase_mode_i = 2'h2;
        tick(1);
        chk({31'h0, follow_en_o}, 32'h0);
        phase_mode_i = 2'h0;
        $display("tracking done");
    endtask
    task automatic t_order();
        acc(1'h1, 8'hE0, 32'h9500, 32'h0);
        on_req_i = 1'h1;
        tick(3);
        peer.emit(0, 5'h14);
        tick(2);
        on_is(1'h0);
        chk({29'h0, state_o}, 32'h1);
        peer.emit(0, 5'h15);
        tick(1);
        on_is(1'h1);
        acc(1'h1, 8'hE0, 32'h008A, 32'h0);
        on_req_i = 1'h0;
        peer.emit(1, 5'h0B);
        tick(4);
        on_is(1'h1);
        chk({29'h0, state_o}, 32'h3);
        peer.emit(1, 5'h0A);
        tick(8);
        on_is(1'h1);
        tick(1);
        on_is(1'h0);
        $display("ordering done");
    endtask
    task automatic t_bcast();
        acc(1'h1, 8'hE2, 32'h00352A23, 32'h0);
        bc(2, 5'h0A, 2'h1);
        bc(2, 5'h0B, 2'h0);
        bc(3, 5'h15, 2'h2);
        bc(3, 5'h0A, 2'h0);
        tx(0, 5'h03);
        tx(1, 5'h0A);
        tx(2, 5'h15);
        acc(1'h1, 8'hE2, 32'h00150A03, 32'h0);
        bc(2, 5'h0A, 2'h0);
        bc(3, 5'h15, 2'h0);
        $display("broadcast done");
    endtask
    task automatic t_fail();
        acc(1'h1, 8'hE0, 32'h0, 32'h0);
        acc(1'h1, 8'hE2, 32'h23, 32'h0);
        on_req_i = 1'h1;
        wait_on(1'h1);
        peer.emit(4, 5'h03);
        on_req_i = 1'h0;
        chk({31'h0, fail_off_o}, 32'h1);
        tick(2);
        on_is(1'h0);
        acc(1'h1, 8'hE2, 32'h03, 32'h0);
        on_req_i = 1'h1;
        wait_on(1'h1);
        peer.emit(4, 5'h03);
        tick(3);
        on_is(1'h1);
        wait_on(1'h0);
        phase_mode_i = 2'h1;
        wait_on(1'h1);
        peer.emit(4, 5'h1C);
        wait_on(1'h0);
        phase_mode_i = 2'h0;
        on_req_i = 1'h0;
        $display("supply loss done");
    endtask
    // Mid-run reset with the ordering strap in use
    task automatic t_strap();
        strap_order_use_i = 1'h1;
        nrst_i = 1'h0;
        tick(2);
        nrst_i = 1'h1;
        tick(4);
        acc(1'h0, 8'hE0, 32'h0, 32'h8A85);
        acc(1'h0, 8'hE2, 32'h0, strap_group_i & 32'h003F3F3F);
        acc(1'h1, 8'hE0, 32'h0083, 32'h0);
        acc(1'h0, 8'hE0, 32'h0, 32'h0083);
        tick(4);
        acc(1'h0, 8'hE0, 32'h0, 32'h0083);
        strap_order_use_i = 1'h0;
        $display("strap done");
    endtask
    initial begin
        tick(2);
        nrst_i = 1'h1;
        tick(4);
        t_regs();
        t_track();
        t_order();
        t_bcast();
        t_fail();
        t_strap();
        wrap_up();
    end
endmodule
